// ==== verilog/ssc_step_sequencer.sv ====
// Step sequencer control: electrical angle counter, drive levels and flags.
// Assumes control inputs asynchronous to core_clk; pull-downs sit at the pads.
//
// Behaviour
// (R1) Standby input low: oscillators stopped, no drive switching.
// (R2) After standby release, drive held off for 0.5 ms settling.
// (R3) Enabled, not initialising: step on each pulse, direction high counts up.
// (R4) Initialise high: angle held at home, step and direction ignored.
// (R5) Output enable low: all four motor outputs high impedance.
// (R6) Angle keeps stepping while outputs are disabled.
// (R7) Standby overrides output enable.
// (R8) Resolutions full to 1/32 step via three select inputs.
// (R9) Host keeps step pulse rate at or below 100 kHz.
// (R10) Home flag is open drain: pulls low or releases, never high.
// (R11) Open-drain fault flag for over-temperature, overcurrent, load open.
// (R12) Separate open-drain stall flag.
// (R13) Undriven inputs read low, so an open standby input means standby.
// (R14) Rising step edge advances angle by one step in chosen direction.
// (R15) Select 000 fixed 71 %, then full, half a, quarter, half b, 1/8, 1/16, 1/32.
// (R16) Resolution change applies at the next rising step edge.
// (R17) Home flag pulls low exactly at the 45 degree home angle.
// (R18) Angle wraps modulo one electrical period, up or down.
// (R19) Inputs synchronised first; step edges detected after synchronisation.
`timescale 1ns/1ps
`default_nettype none

module ssc_step_sequencer
    import ssc_pkg::*;
#(
    parameter int SETTLE_CYCLES = `SSC_SETTLE_CYCLES,
    parameter int FCLR_CYCLES   = `SSC_FCLR_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       standby_n,
    input  wire logic       output_enable,
    input  wire logic       angle_init,
    input  wire logic       step_pulse,
    input  wire logic       direction_select,
    input  wire logic       step_res_sel0,
    input  wire logic       step_res_sel1,
    input  wire logic       step_res_sel2,
    input  wire logic       over_temp_det,
    input  wire logic       over_current_det,
    input  wire logic       load_open_det,
    input  wire logic       stall_det,
    output logic            oscillators_run,
    output logic            phase_a_pos_out,
    output logic            phase_a_neg_out,
    output logic            phase_b_pos_out,
    output logic            phase_b_neg_out,
    output logic            phase_out_oe_n,
    output logic      [7:0] phase_a_level,
    output logic      [7:0] phase_b_level,
    output logic            angle_home_flag_n,
    output logic            angle_home_flag_oe_n,
    output logic            fault_flag_n,
    output logic            fault_flag_oe_n,
    output logic            stall_flag_n,
    output logic            stall_flag_oe_n
);

    localparam logic [14:0] SETTLE_LAST = 15'(SETTLE_CYCLES - 1);
    localparam logic [14:0] FCLR_LAST   = 15'(FCLR_CYCLES - 1);

    // Whole state of the block
    typedef struct packed {
        ssc_ctrl_s  sync1;
        ssc_ctrl_s  sync2;
        logic       step_prev;
        ssc_fsm_e   fsm;
        logic [14:0] settle_cnt;
        logic [14:0] fclr_cnt;
        ssc_res_e   res;
        logic [6:0] angle;
        logic       a_pos_d1;
        logic       b_pos_d1;
        logic [1:0] ovr_d1;
        logic       fault_latch;
        logic       osc_run;
        ssc_drive_s drv;
        logic       drv_oe_n;
        logic       home_oe_n;
        logic       fault_oe_n;
        logic       stall_oe_n;
    } ssc_state_s;

    ssc_state_s state_q;
    ssc_state_s state_d;
    ssc_ctrl_s  ctrl_in;
    logic [5:0] rom_addr_a;
    logic [5:0] rom_addr_b;
    logic [7:0] rom_a_q;
    logic [7:0] rom_b_q;
    logic       step_edge;

    // Step size in 1/32 units for each resolution
    function automatic logic [6:0] step_size(input ssc_res_e r);
        logic [6:0] s;
        s = 7'h00;
        case (r)
            SSC_RES_FULL:                  s = `SSC_STEP_FULL;
            SSC_RES_HALF_A, SSC_RES_HALF_B: s = `SSC_STEP_HALF;
            SSC_RES_QUARTER:               s = `SSC_STEP_QUARTER;
            SSC_RES_EIGHTH:                s = `SSC_STEP_EIGHTH;
            SSC_RES_SIXTEENTH:             s = `SSC_STEP_SIXTEENTH;
            SSC_RES_THIRTYSEC:             s = `SSC_STEP_THIRTYSEC;
            default:                       s = 7'h00;
        endcase
        return s;
    endfunction : step_size

    ////////////////////////////////////////////////////////////////////////////
    // Input gathering and table

    // Pad pull-downs make undriven inputs low; no logic needed here (see R13)
    assign ctrl_in = '{standby_n, output_enable, angle_init, step_pulse, direction_select,
                       {step_res_sel0, step_res_sel1, step_res_sel2},
                       over_temp_det, over_current_det, load_open_det, stall_det};

    // Edge seen only after the second stage (see R19)
    assign step_edge = state_q.sync2.step_pulse && !state_q.step_prev;

    // Phase A follows cosine, phase B sine; A leads when counting up
    always_comb begin
        if (state_q.angle[5]) begin
            rom_addr_a = {1'b0, state_q.angle[4:0]};
            rom_addr_b = `SSC_QUAD_STEPS - {1'b0, state_q.angle[4:0]};
        end else begin
            rom_addr_a = `SSC_QUAD_STEPS - {1'b0, state_q.angle[4:0]};
            rom_addr_b = {1'b0, state_q.angle[4:0]};
        end
    end

    ssc_sine_rom u_rom (
        .core_clk (core_clk),
        .reset    (reset),
        .addr_a   (rom_addr_a),
        .addr_b   (rom_addr_b),
        .data_a_q (rom_a_q),
        .data_b_q (rom_b_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_d = state_q;
        // Two-stage synchroniser, first stage feeds only the second (see R19)
        state_d.sync1     = ctrl_in;
        state_d.sync2     = state_q.sync1;
        state_d.step_prev = state_q.sync2.step_pulse;

        // Power sequencing; standby wins over everything (see R1) (see R7)
        case (state_q.fsm)
            SSC_ST_STANDBY: begin
                state_d.settle_cnt = 15'h0000;
                if (state_q.sync2.standby_n) begin
                    state_d.fsm = SSC_ST_SETTLE;
                end
            end
            SSC_ST_SETTLE: begin
                state_d.settle_cnt = state_q.settle_cnt + 15'h0001;
                if (!state_q.sync2.standby_n) begin
                    state_d.fsm = SSC_ST_STANDBY;
                end else if (state_q.settle_cnt == SETTLE_LAST) begin
                    state_d.fsm = SSC_ST_RUN; // see R2
                end
            end
            SSC_ST_RUN: begin
                if (!state_q.sync2.standby_n) begin
                    state_d.fsm = SSC_ST_STANDBY;
                end
            end
            default: state_d.fsm = SSC_ST_STANDBY;
        endcase
        state_d.osc_run = (state_d.fsm != SSC_ST_STANDBY); // see R1

        // Angle counter runs whenever oscillators run, enable or not (see R6)
        if (state_q.fsm != SSC_ST_STANDBY && state_q.sync2.standby_n) begin
            if (state_q.sync2.angle_init) begin
                state_d.angle = `SSC_ANGLE_HOME; // see R4
            end else if (step_edge) begin
                // Resolution sampled only on the step edge (see R16) (see R8)
                state_d.res = ssc_res_e'(state_q.sync2.step_res_sel);
                if (state_d.res == SSC_RES_FIXED) begin
                    state_d.angle = `SSC_ANGLE_HOME; // see R15
                end else if (state_q.sync2.direction_select) begin
                    state_d.angle = state_q.angle + step_size(state_d.res); // see R3 R14 R18
                end else begin
                    state_d.angle = state_q.angle - step_size(state_d.res); // see R3 R14 R18
                end
            end
        end

        // Polarity and override, delayed to line up with the table read
        state_d.a_pos_d1 = (state_q.angle[6:5] == 2'b00) || (state_q.angle[6:5] == 2'b11);
        state_d.b_pos_d1 = !state_q.angle[6];
        if (state_q.res == SSC_RES_FIXED) begin
            state_d.ovr_d1 = 2'b10;
        end else if ((state_q.res == SSC_RES_FULL || state_q.res == SSC_RES_HALF_A)
                     && state_q.angle[3:0] == 4'h0 && state_q.angle[4]) begin
            state_d.ovr_d1 = 2'b01; // Full drive on the diagonals
        end else begin
            state_d.ovr_d1 = 2'b00;
        end
        state_d.drv.phase_a_pos_out = state_q.a_pos_d1;
        state_d.drv.phase_a_neg_out = !state_q.a_pos_d1;
        state_d.drv.phase_b_pos_out = state_q.b_pos_d1;
        state_d.drv.phase_b_neg_out = !state_q.b_pos_d1;
        case (state_q.ovr_d1)
            2'b10: begin
                state_d.drv.phase_a_level = `SSC_LEVEL_71; // see R15
                state_d.drv.phase_b_level = `SSC_LEVEL_71;
            end
            2'b01: begin
                state_d.drv.phase_a_level = `SSC_LEVEL_FULL;
                state_d.drv.phase_b_level = `SSC_LEVEL_FULL;
            end
            default: begin
                state_d.drv.phase_a_level = rom_a_q;
                state_d.drv.phase_b_level = rom_b_q;
            end
        endcase

        // Bridge released unless running and enabled (see R5) (see R7) (see R2)
        state_d.drv_oe_n = !(state_d.fsm == SSC_ST_RUN && state_q.sync2.output_enable);

        // Latched faults clear after enable has been low long enough; set wins
        if (state_q.sync2.output_enable || !state_q.fault_latch) begin
            state_d.fclr_cnt = 15'h0000;
        end else if (state_q.fclr_cnt != FCLR_LAST) begin
            state_d.fclr_cnt = state_q.fclr_cnt + 15'h0001;
        end
        if (state_q.fsm == SSC_ST_STANDBY) begin
            state_d.fault_latch = 1'b0;
        end else if (state_q.sync2.over_temp_det || state_q.sync2.over_current_det) begin
            state_d.fault_latch = 1'b1;
        end else if (state_q.fclr_cnt == FCLR_LAST) begin
            state_d.fault_latch = 1'b0;
        end

        // Open-drain flags; logic is unpowered in standby so all release
        if (state_d.fsm == SSC_ST_STANDBY) begin
            state_d.home_oe_n  = 1'b1;
            state_d.fault_oe_n = 1'b1;
            state_d.stall_oe_n = 1'b1;
        end else begin
            state_d.home_oe_n  = (state_d.angle != `SSC_ANGLE_HOME); // see R17 R10
            state_d.fault_oe_n = !(state_d.fault_latch || state_q.sync2.load_open_det); // see R11
            state_d.stall_oe_n = !state_q.sync2.stall_det; // see R12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q            <= '0;
            state_q.fsm        <= SSC_ST_STANDBY;
            state_q.res        <= SSC_RES_FIXED;
            state_q.angle      <= `SSC_ANGLE_RESET;
            state_q.drv_oe_n   <= 1'b1;
            state_q.home_oe_n  <= 1'b1;
            state_q.fault_oe_n <= 1'b1;
            state_q.stall_oe_n <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs straight from state flops; flag data is constant low (open drain)
    assign oscillators_run      = state_q.osc_run;
    assign phase_a_pos_out      = state_q.drv.phase_a_pos_out;
    assign phase_a_neg_out      = state_q.drv.phase_a_neg_out;
    assign phase_b_pos_out      = state_q.drv.phase_b_pos_out;
    assign phase_b_neg_out      = state_q.drv.phase_b_neg_out;
    assign phase_out_oe_n       = state_q.drv_oe_n;
    assign phase_a_level        = state_q.drv.phase_a_level;
    assign phase_b_level        = state_q.drv.phase_b_level;
    assign angle_home_flag_n    = 1'b0;
    assign angle_home_flag_oe_n = state_q.home_oe_n;
    assign fault_flag_n         = 1'b0;
    assign fault_flag_oe_n      = state_q.fault_oe_n;
    assign stall_flag_n         = 1'b0;
    assign stall_flag_oe_n      = state_q.stall_oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    logic awake;
    assign awake = state_q.fsm != SSC_ST_STANDBY && state_q.sync2.standby_n;

    property p_standby_off;
        !state_q.sync2.standby_n |=> phase_out_oe_n && !oscillators_run;
    endproperty
    a_standby_off: assert property (p_standby_off) else $error("standby left drive or osc on"); // see R1 R7

    property p_settle_hold;
        state_q.fsm == SSC_ST_STANDBY && state_q.sync2.standby_n |=> phase_out_oe_n [*8];
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("drive on during settling"); // see R2

    property p_step_up;
        awake && !state_q.sync2.angle_init && step_edge && state_q.sync2.direction_select
            && state_q.sync2.step_res_sel != 3'b000
        |=> state_q.angle == 7'($past(state_q.angle)
                + step_size(ssc_res_e'($past(state_q.sync2.step_res_sel))));
    endproperty
    a_step_up: assert property (p_step_up) else $error("up step wrong"); // see R3 R14 R16 R18

    property p_step_down;
        awake && !state_q.sync2.angle_init && step_edge && !state_q.sync2.direction_select
            && state_q.sync2.step_res_sel != 3'b000
        |=> state_q.angle == 7'($past(state_q.angle)
                - step_size(ssc_res_e'($past(state_q.sync2.step_res_sel))));
    endproperty
    a_step_down: assert property (p_step_down) else $error("down step wrong"); // see R3 R14 R18

    property p_init_hold;
        awake && state_q.sync2.angle_init |=> state_q.angle == `SSC_ANGLE_HOME;
    endproperty
    a_init_hold: assert property (p_init_hold) else $error("init did not hold home"); // see R4

    property p_disable_hiz;
        !state_q.sync2.output_enable |=> phase_out_oe_n;
    endproperty
    a_disable_hiz: assert property (p_disable_hiz) else $error("drive on while disabled"); // see R5

    property p_count_disabled;
        awake && !state_q.sync2.output_enable && !state_q.sync2.angle_init && step_edge
            && state_q.sync2.step_res_sel != 3'b000
        |=> state_q.angle != $past(state_q.angle);
    endproperty
    a_count_disabled: assert property (p_count_disabled) else $error("no count when off"); // see R6

    property p_fixed_mode;
        awake && step_edge && state_q.sync2.step_res_sel == 3'b000 |=>
            state_q.angle == `SSC_ANGLE_HOME ##2 phase_a_level == `SSC_LEVEL_71;
    endproperty
    a_fixed_mode: assert property (p_fixed_mode) else $error("fixed mode wrong"); // see R8 R15

    property p_home_flag;
        state_q.fsm != SSC_ST_STANDBY ##1 state_q.fsm != SSC_ST_STANDBY
        |-> angle_home_flag_oe_n == (state_q.angle != `SSC_ANGLE_HOME);
    endproperty
    a_home_flag: assert property (p_home_flag) else $error("home flag mismatch"); // see R17 R10

    property p_fault_flag;
        awake && state_q.sync2.over_temp_det |=> !fault_flag_oe_n;
    endproperty
    a_fault_flag: assert property (p_fault_flag) else $error("fault flag missed"); // see R11

    property p_stall_flag;
        awake && state_q.sync2.stall_det |=> !stall_flag_oe_n;
    endproperty
    a_stall_flag: assert property (p_stall_flag) else $error("stall flag missed"); // see R12

    c_step_up:  cover property (awake && step_edge && state_q.sync2.direction_select);
    c_init:     cover property (awake && state_q.sync2.angle_init);
    c_run:      cover property (state_q.fsm == SSC_ST_RUN && !phase_out_oe_n);

endmodule : ssc_step_sequencer

`default_nettype wire

// ==== inc/ssc_consts.svh ====
// Constants for the step sequencer control block: angles, levels, timing.
// Assumes a single 50 MHz core clock; included by bare name.
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// Electrical angle: 128 positions per period, 32 per quadrant
`define SSC_ANGLE_W          7
`define SSC_ANGLE_HOME       7'h10
`define SSC_ANGLE_RESET      7'h10
`define SSC_QUAD_STEPS       6'h20

// Step sizes in 1/32 step units
`define SSC_STEP_FULL        7'h20
`define SSC_STEP_HALF        7'h10
`define SSC_STEP_QUARTER     7'h08
`define SSC_STEP_EIGHTH      7'h04
`define SSC_STEP_SIXTEENTH   7'h02
`define SSC_STEP_THIRTYSEC   7'h01

// Current levels, 8'hFF is 100 %
`define SSC_LEVEL_W          8
`define SSC_LEVEL_71         8'hB4
`define SSC_LEVEL_FULL       8'hFF

// Timing
`define SSC_CLK_PERIOD_NS    20
`define SSC_SETTLE_TIME_NS   500000
`define SSC_SETTLE_CYCLES    ((`SSC_SETTLE_TIME_NS + `SSC_CLK_PERIOD_NS - 1) / `SSC_CLK_PERIOD_NS)
`define SSC_FCLR_TIME_NS     200000
`define SSC_FCLR_CYCLES      ((`SSC_FCLR_TIME_NS + `SSC_CLK_PERIOD_NS - 1) / `SSC_CLK_PERIOD_NS)
`define SSC_CNT_W            15

`endif

// ==== inc/ssc_pkg.sv ====
// Types for the step sequencer control block.
// Assumes ssc_consts.svh is on the include path.
`include "ssc_consts.svh"

package ssc_pkg;

    // Step resolution select, first select input most significant
    typedef enum logic [2:0] {
        SSC_RES_FIXED     = 3'b000,
        SSC_RES_FULL      = 3'b001,
        SSC_RES_HALF_A    = 3'b010,
        SSC_RES_QUARTER   = 3'b011,
        SSC_RES_HALF_B    = 3'b100,
        SSC_RES_EIGHTH    = 3'b101,
        SSC_RES_SIXTEENTH = 3'b110,
        SSC_RES_THIRTYSEC = 3'b111
    } ssc_res_e;

    // Power state of the block
    typedef enum logic [1:0] {
        SSC_ST_STANDBY = 2'b00,
        SSC_ST_SETTLE  = 2'b01,
        SSC_ST_RUN     = 2'b10
    } ssc_fsm_e;

    // Control inputs as sampled together
    typedef struct packed {
        logic       standby_n;
        logic       output_enable;
        logic       angle_init;
        logic       step_pulse;
        logic       direction_select;
        logic [2:0] step_res_sel;
        logic       over_temp_det;
        logic       over_current_det;
        logic       load_open_det;
        logic       stall_det;
    } ssc_ctrl_s;

    // Drive towards the bridge: polarity per phase and current level
    typedef struct packed {
        logic       phase_a_pos_out;
        logic       phase_a_neg_out;
        logic       phase_b_pos_out;
        logic       phase_b_neg_out;
        logic [7:0] phase_a_level;
        logic [7:0] phase_b_level;
    } ssc_drive_s;

endpackage : ssc_pkg

// ==== verilog/ssc_sine_rom.sv ====
// Two-port quarter-wave sine table, 33 entries, registered read data.
// Assumes addresses 0..32; higher addresses read as full scale.
`timescale 1ns/1ps
`default_nettype none

module ssc_sine_rom
    import ssc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic [5:0] addr_a,
    input  wire logic [5:0] addr_b,
    output logic      [7:0] data_a_q,
    output logic      [7:0] data_b_q
);

    // sin(k * 90 / 32) scaled to 8'hFF
    function automatic logic [7:0] sine_lookup(input logic [5:0] k);
        logic [7:0] v;
        v = 8'hFF;
        case (k)
            6'h00: v = 8'h00; 6'h01: v = 8'h0D; 6'h02: v = 8'h19; 6'h03: v = 8'h25;
            6'h04: v = 8'h32; 6'h05: v = 8'h3E; 6'h06: v = 8'h4A; 6'h07: v = 8'h56;
            6'h08: v = 8'h62; 6'h09: v = 8'h6D; 6'h0A: v = 8'h78; 6'h0B: v = 8'h83;
            6'h0C: v = 8'h8E; 6'h0D: v = 8'h99; 6'h0E: v = 8'hA3; 6'h0F: v = 8'hAD;
            6'h10: v = 8'hB4; 6'h11: v = 8'hBD; 6'h12: v = 8'hC5; 6'h13: v = 8'hCD;
            6'h14: v = 8'hD4; 6'h15: v = 8'hDB; 6'h16: v = 8'hE1; 6'h17: v = 8'hE7;
            6'h18: v = 8'hEC; 6'h19: v = 8'hF0; 6'h1A: v = 8'hF4; 6'h1B: v = 8'hF7;
            6'h1C: v = 8'hFA; 6'h1D: v = 8'hFC; 6'h1E: v = 8'hFE;
            default: v = 8'hFF;
        endcase
        return v;
    endfunction : sine_lookup

    // Registered read keeps the table off the output timing path
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            data_a_q <= 8'h00;
            data_b_q <= 8'h00;
        end else begin
            data_a_q <= sine_lookup(addr_a);
            data_b_q <= sine_lookup(addr_b);
        end
    end

endmodule : ssc_sine_rom

`default_nettype wire

// ==== tb/ssc_host_model.sv ====
// Host controller model: step pulses and rotation direction.
// Assumes a 50 MHz core_clk; the bench calls step_once hierarchically.
`timescale 1ns/1ps
`default_nettype none

module ssc_host_model #(
    parameter int HALF_CYC = 250
) (
    input  wire logic core_clk,
    output logic      step_pulse,
    output logic      direction_select
);
    ////////////////////////////////////////////////////////////////////////
    // Idle low, as the pad pull-down leaves an undriven pin
    initial begin
        step_pulse       = 1'b0;
        direction_select = 1'b0;
    end

    // One step; a whole period of 500 cycles keeps the rate at 100 kHz
    task automatic step_once(input logic dir);
        @(negedge core_clk);
        direction_select = dir;
        step_pulse       = 1'b1;
        repeat (HALF_CYC) @(negedge core_clk);
        step_pulse = 1'b0;
        repeat (HALF_CYC) @(negedge core_clk);
    endtask : step_once
endmodule : ssc_host_model

`default_nettype wire

// ==== tb/tb_top.sv ====
// Testbench for the step sequencer: power, stepping, modes and flags.
// Assumes short settle and fault-clear counts; inputs change on negedge.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import ssc_pkg::*;
    logic core_clk, reset, standby_n, output_enable, angle_init;
    logic over_temp_det, over_current_det, load_open_det, stall_det;
    logic [2:0] res;
    logic step_pulse, direction_select, oscillators_run, phase_out_oe_n;
    logic phase_a_pos_out, phase_a_neg_out, phase_b_pos_out, phase_b_neg_out;
    logic [7:0] phase_a_level, phase_b_level;
    logic angle_home_flag_n, angle_home_flag_oe_n, fault_flag_n, fault_flag_oe_n;
    logic stall_flag_n, stall_flag_oe_n;
    int   error_cnt, check_count, i;
    // Bridge polarity per quadrant on the wrap walk: A follows cosine, B sine
    logic [3:0] pol_exp [8] = '{4'h6, 4'h5, 4'h9, 4'hA, 4'h9, 4'h5, 4'h6, 4'hA};

    ////////////////////////////////////////////////////////////////////////
    // Short counts so the power-up and fault clear stay quick
    ssc_step_sequencer #(.SETTLE_CYCLES(8), .FCLR_CYCLES(4)) u_dut (
        .core_clk, .reset, .standby_n, .output_enable, .angle_init,
        .step_pulse, .direction_select, .step_res_sel0(res[2]),
        .step_res_sel1(res[1]), .step_res_sel2(res[0]), .over_temp_det,
        .over_current_det, .load_open_det, .stall_det, .oscillators_run,
        .phase_a_pos_out, .phase_a_neg_out, .phase_b_pos_out, .phase_b_neg_out,
        .phase_out_oe_n, .phase_a_level, .phase_b_level, .angle_home_flag_n,
        .angle_home_flag_oe_n, .fault_flag_n, .fault_flag_oe_n, .stall_flag_n,
        .stall_flag_oe_n
    );
    ssc_host_model u_host (.core_clk, .step_pulse, .direction_select);

    // Clock, 20 ns period
    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_n

    ////////////////////////////////////////////////////////////////////////
    // Hang guard, far beyond the ~13600 cycles the sequence needs
    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        stop_test();
    end

    // Main sequence
    initial begin
        reset = 1'b1;
        standby_n = 1'b0;
        output_enable = 1'b0;
        angle_init = 1'b0;
        res = 3'b001;
        {over_temp_det, over_current_det, load_open_det, stall_det} = 4'h0;
        error_cnt = 0;
        check_count = 0;
        wait_n(2);
        reset = 1'b0;
        wait_n(4);
        chk(oscillators_run, 1'b0);
        chk(phase_out_oe_n, 1'b1);
        {standby_n, output_enable} = 2'b11;
        wait_n(6);
        chk(phase_out_oe_n, 1'b1);
        wait_n(10);
        chk({oscillators_run, phase_out_oe_n}, 2'b10);
        // Every mode: one step out and back lands on home with its level
        for (i = 0; i < 8; i++) begin
            res = i[2:0];
            u_host.step_once(1'b1);
            u_host.step_once(1'b0);
            chk(angle_home_flag_oe_n, 1'b0);
            chk({phase_a_level, phase_b_level}, (i == 1 || i == 2) ?
                16'hFFFF : {`SSC_LEVEL_71, `SSC_LEVEL_71});
        end
        // Full steps wrap after four, both ways
        res = 3'b001;
        for (i = 0; i < 8; i++) begin
            u_host.step_once(i < 4);
            chk(angle_home_flag_oe_n, (i % 4) != 3);
            chk({phase_a_level, phase_b_level}, 16'hFFFF);
            chk({phase_a_pos_out, phase_a_neg_out, phase_b_pos_out, phase_b_neg_out}, pol_exp[i]);
        end
        // A select change alone must not move the levels
        res = 3'b000;
        wait_n(8);
        chk({phase_a_level, phase_b_level}, 16'hFFFF);
        res = 3'b001;
        // Initialise pulls home at once and ignores steps
        u_host.step_once(1'b1);
        angle_init = 1'b1;
        wait_n(5);
        chk(angle_home_flag_oe_n, 1'b0);
        u_host.step_once(1'b1);
        chk(angle_home_flag_oe_n, 1'b0);
        angle_init = 1'b0;
        // Latched fault: flag stays low after over-temperature goes
        over_temp_det = 1'b1;
        wait_n(6);
        over_temp_det = 1'b0;
        wait_n(6);
        chk(fault_flag_oe_n, 1'b0);
        // Disabled: bridge off, angle keeps counting, latch clears
        output_enable = 1'b0;
        wait_n(5);
        chk(phase_out_oe_n, 1'b1);
        u_host.step_once(1'b1);
        chk(angle_home_flag_oe_n, 1'b1);
        chk(fault_flag_oe_n, 1'b1);
        // Overcurrent latches too, and clears once gone with enable low
        over_current_det = 1'b1;
        wait_n(6);
        chk(fault_flag_oe_n, 1'b0);
        over_current_det = 1'b0;
        wait_n(6);
        chk(fault_flag_oe_n, 1'b1);
        load_open_det = 1'b1;
        stall_det = 1'b1;
        wait_n(6);
        chk({fault_flag_oe_n, stall_flag_oe_n}, 2'b00);
        chk({angle_home_flag_n, fault_flag_n, stall_flag_n}, 3'b000);
        load_open_det = 1'b0;
        wait_n(6);
        chk(fault_flag_oe_n, 1'b1);
        // Standby beats enable
        output_enable = 1'b1;
        wait_n(6);
        chk(phase_out_oe_n, 1'b0);
        standby_n = 1'b0;
        wait_n(5);
        chk({oscillators_run, phase_out_oe_n, stall_flag_oe_n}, 3'b011);
        stop_test();
    end
endmodule : tb_top

`default_nettype wire
